// file: core/timer_one.sv
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// Notes on behaviour
// - clock select clear: count instruction clock, sync disable ignored
// - clock select set: count rising external edges, source chosen by oscillator enable
// - synchronised mode samples prescaler output; prescaler is ripple divider of edges
// - synchronised mode in sleep: count holds, prescaler keeps counting
// - prescaler output sampled on second and fourth phase ticks
// - synchronised increment lands a fixed delay after the detected edge
// - sync disabled: counts asynchronously, runs in sleep, overflow may wake
// - asynchronous counting gives no time base to compare
// - byte reads return a consistent byte even when counting asynchronously
// - crystal oscillator active when enabled, runs in sleep, 32.768 kHz target
// - compare special trigger resets the count to zero
// - trigger reset guaranteed only in timer or synchronised mode
// - count write in same cycle as trigger wins
// - with trigger active, compare pair acts as period register
// - count bytes survive every reset; only the trigger or a count byte write clears them
// - control clears on power-on or brown-out only
// - any count byte write clears the prescaler
// - prescaler output is a symmetrical square wave for codes 01 to 11; code 00 passes the raw source
// - sync disable bypasses synchroniser with external clock, else synchronises
module timer_one
(
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic POR_RST,
	input wire logic SLEEP,
	input wire logic EXT_CLOCK_PIN,
	input wire logic OSC_INPUT_PIN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic OSC_OUTPUT_PIN,
	output logic OSC_OUTPUT_OE,
	output logic IRQ,
	output logic WAKE
);

	// architectural registers and the count path
	logic [7:0] ctl_r;
	logic [7:0] intc_r;
	logic [7:0] pir_r;
	logic [7:0] pie_r;
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic [15:0] compare_r;
	logic [3:0] mode_r;
	logic [2:0] ps_r;
	logic [1:0] phase_r;
	logic ext_d_r;
	logic ps_out_s1_r;
	logic ps_out_s2_r;
	logic ps_out_prev_r;
	logic [1:0] delay_r;
	// single-cycle strobes and combinational signals decoded each clock
	logic ovf_set;
	logic trig_reset;
	logic tick;
	logic ext_rise;
	logic ps_out;
	logic ext_src;
	logic wr_count;
	logic [7:0] wdata8;
	timer_one_pkg::bus_req_t req_r;
	timer_one_pkg::sync_state_t sync_st_r;

	// decode a word address into a register index; unmapped goes nowhere
	function automatic logic [7:0] word_index(input logic [31:0] a);
		word_index = a[9:2];
	endfunction

	// divide ratio code to prescaler bit
	function automatic logic ps_tap(input logic [2:0] p, input logic [1:0] sel);
		case (sel)
			2'h0: ps_tap = 1'b0;
			2'h1: ps_tap = p[0];
			2'h2: ps_tap = p[1];
			default: ps_tap = p[2];
		endcase
	endfunction

	// low prescaler bits that must all be set when the divided edge arrives
	function automatic logic [2:0] ps_mask(input logic [1:0] sel);
		case (sel)
			2'h0: ps_mask = 3'h0;
			2'h1: ps_mask = 3'h1;
			2'h2: ps_mask = 3'h3;
			default: ps_mask = 3'h7;
		endcase
	endfunction

	// data phase write to one register index
	function automatic logic wr_hit(input timer_one_pkg::bus_req_t r, input logic [7:0] idx);
		wr_hit = r.write && (r.idx == idx);
	endfunction

	// control fields and the modes they select
	wire on = ctl_r[timer_one_pkg::CTL_ON];
	wire ext_mode = ctl_r[timer_one_pkg::CTL_CLKSEL];
	wire sync_dis = ctl_r[timer_one_pkg::CTL_SYNC_DIS];
	wire osc_en = ctl_r[timer_one_pkg::CTL_OSC_EN];
	wire [1:0] ps_sel = ctl_r[timer_one_pkg::CTL_PS_HI:timer_one_pkg::CTL_PS_LO];
	wire async_mode = ext_mode && sync_dis;
	wire trig_mode = (mode_r == timer_one_pkg::MODE_SPECIAL_TRIGGER);

	// crystal pin chosen when oscillator enabled, else the clock pin
	assign ext_src = osc_en ? OSC_INPUT_PIN : EXT_CLOCK_PIN;

	// rising edge of the external source; inputs are clock-synchronous here
	assign ext_rise = ext_src && !ext_d_r;

	// bus data phase write of count bytes
	assign wdata8 = HWDATA[7:0];
	assign wr_count = wr_hit(req_r, timer_one_pkg::IDX_COUNT_LOW_BYTE)
		|| wr_hit(req_r, timer_one_pkg::IDX_COUNT_HIGH_BYTE);

	// phase counter: one instruction cycle is four oscillator phases
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
			phase_r <= 2'h0;
		else
			phase_r <= phase_r + 2'h1;
	end

	// ripple-style prescaler on external edges; keeps running in sleep
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			ps_r <= 3'h0;
			ext_d_r <= 1'b0;
		end
		else
		begin
			ext_d_r <= ext_src;
			if (wr_count)
				ps_r <= 3'h0;
			else if (ext_mode && ext_rise)
				ps_r <= ps_r + 3'h1;
		end
	end

	// code 00 passes raw source; others give a half-duty divided wave
	assign ps_out = (ps_sel == 2'h0) ? ext_src : ps_tap(ps_r, ps_sel);

	// sample prescaler output on second and fourth phase only
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			ps_out_s1_r <= 1'b0;
			ps_out_s2_r <= 1'b0;
			ps_out_prev_r <= 1'b0;
		end
		else if (!SLEEP && (phase_r == timer_one_pkg::PHASE_SECOND
			|| phase_r == timer_one_pkg::PHASE_FOURTH))
		begin
			ps_out_s1_r <= ps_out;
			ps_out_s2_r <= ps_out_s1_r;
			ps_out_prev_r <= ps_out_s2_r;
		end
	end

	// hold a detected edge for a fixed delay before it counts
	// the fastest legal input leaves no second edge inside this wait
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			sync_st_r <= timer_one_pkg::ST_IDLE;
			delay_r <= 2'h0;
		end
		else
		begin
			case (sync_st_r)
				timer_one_pkg::ST_IDLE:
					if (!SLEEP && ps_out_s2_r && !ps_out_prev_r
						&& (phase_r == timer_one_pkg::PHASE_SECOND
						|| phase_r == timer_one_pkg::PHASE_FOURTH))
					begin
						sync_st_r <= timer_one_pkg::ST_WAIT;
						delay_r <= 2'(timer_one_pkg::SYNC_INC_DELAY - 1);
					end
				timer_one_pkg::ST_WAIT:
					if (delay_r == 2'h0)
						sync_st_r <= timer_one_pkg::ST_IDLE;
					else
						delay_r <= delay_r - 2'h1;
				default:
					sync_st_r <= timer_one_pkg::ST_IDLE;
			endcase
		end
	end

	// count tick source by mode
	always_comb
	begin
		if (!on)
			tick = 1'b0;
		else if (!ext_mode)
			tick = (phase_r == timer_one_pkg::PHASE_FOURTH) && !SLEEP;
		else if (sync_dis)
			// ripple count wraps at eight, so only the selected low bits matter
			tick = ext_rise
				&& ((ps_r & ps_mask(ps_sel)) == ps_mask(ps_sel));
		else
			tick = (sync_st_r == timer_one_pkg::ST_WAIT) && (delay_r == 2'h0)
				&& !SLEEP;
	end

	// trigger only honoured in timer or synchronised mode
	assign trig_reset = trig_mode && on && !async_mode && tick
		&& (count_r == compare_r);

	// bus write applied last so it overrides the trigger reset
	always_comb
	begin
		count_nxt = count_r;
		ovf_set = 1'b0;
		if (trig_reset)
			count_nxt = 16'h0000;
		else if (tick)
		begin
			count_nxt = count_r + 16'h0001;
			ovf_set = (count_r == 16'hffff);
		end
		if (wr_hit(req_r, timer_one_pkg::IDX_COUNT_LOW_BYTE))
			count_nxt = {count_r[15:8], wdata8};
		if (wr_hit(req_r, timer_one_pkg::IDX_COUNT_HIGH_BYTE))
			count_nxt = {wdata8, count_r[7:0]};
	end

	// count has no reset: contents survive every reset
	always_ff @(posedge CLOCK)
	begin
		count_r <= count_nxt;
	end

	// control cleared only by power-on or brown-out
	always_ff @(posedge CLOCK or posedge POR_RST)
	begin
		if (POR_RST)
			ctl_r <= timer_one_pkg::CTL_RESET;
		else if (wr_hit(req_r, timer_one_pkg::IDX_TIMER_CONTROL))
			ctl_r <= wdata8 & timer_one_pkg::CTL_MASK;
	end

	// flags, enables, compare settings; hardware set beats software clear
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			pir_r <= timer_one_pkg::PIR_RESET;
			pie_r <= timer_one_pkg::PIE_RESET;
			intc_r <= timer_one_pkg::INTC_RESET;
			compare_r <= 16'hffff;
			mode_r <= 4'h0;
		end
		else
		begin
			if (wr_hit(req_r, timer_one_pkg::IDX_PERIPHERAL_IRQ_FLAGS))
				pir_r <= wdata8 & timer_one_pkg::PIR_MASK;
			if (ovf_set)
				pir_r[timer_one_pkg::PIR_OVF] <= 1'b1;
			if (wr_hit(req_r, timer_one_pkg::IDX_PERIPHERAL_IRQ_ENABLES))
				pie_r <= wdata8 & timer_one_pkg::PIR_MASK;
			if (wr_hit(req_r, timer_one_pkg::IDX_INTERRUPT_CONTROL))
				intc_r <= wdata8;
			if (wr_hit(req_r, timer_one_pkg::IDX_COMPARE_LOW))
				compare_r[7:0] <= wdata8;
			if (wr_hit(req_r, timer_one_pkg::IDX_COMPARE_HIGH))
				compare_r[15:8] <= wdata8;
			if (wr_hit(req_r, timer_one_pkg::IDX_COMPARE_MODE))
				mode_r <= wdata8[3:0];
		end
	end

	// ahb address phase capture; zero wait states
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
			req_r <= '0;
		else if (HREADY)
		begin
			req_r.write <= HSEL && HTRANS == timer_one_pkg::HTRANS_NONSEQ && HWRITE;
			req_r.idx <= word_index(HADDR);
		end
		else
			req_r.write <= 1'b0;
	end

	// read data registered at the address phase; count is a clocked copy
	// one clocked sample per read, so a byte is never torn
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
			HRDATA <= 32'h00000000;
		else if (HREADY && HSEL && HTRANS == timer_one_pkg::HTRANS_NONSEQ && !HWRITE)
		begin
			case (word_index(HADDR))
				timer_one_pkg::IDX_INTERRUPT_CONTROL: HRDATA <= {24'h0, intc_r};
				timer_one_pkg::IDX_PERIPHERAL_IRQ_FLAGS: HRDATA <= {24'h0, pir_r};
				timer_one_pkg::IDX_COUNT_LOW_BYTE: HRDATA <= {24'h0, count_r[7:0]};
				timer_one_pkg::IDX_COUNT_HIGH_BYTE: HRDATA <= {24'h0, count_r[15:8]};
				timer_one_pkg::IDX_TIMER_CONTROL: HRDATA <= {24'h0, ctl_r};
				timer_one_pkg::IDX_PERIPHERAL_IRQ_ENABLES: HRDATA <= {24'h0, pie_r};
				timer_one_pkg::IDX_COMPARE_LOW: HRDATA <= {24'h0, compare_r[7:0]};
				timer_one_pkg::IDX_COMPARE_HIGH: HRDATA <= {24'h0, compare_r[15:8]};
				timer_one_pkg::IDX_COMPARE_MODE: HRDATA <= {28'h0, mode_r};
				default: HRDATA <= 32'h00000000;
			endcase
		end
	end

	// always ready, always okay
	// low only while reset is held
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			HREADYOUT <= 1'b0;
			HRESP <= 1'b0;
		end
		else
		begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end

	// interrupt and wake; async counting wakes from sleep on overflow
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			IRQ <= 1'b0;
			WAKE <= 1'b0;
		end
		else
		begin
			IRQ <= pir_r[timer_one_pkg::PIR_OVF] && pie_r[timer_one_pkg::PIR_OVF]
				&& intc_r[timer_one_pkg::INTC_PEIE] && intc_r[timer_one_pkg::INTC_GIE];
			WAKE <= SLEEP && pir_r[timer_one_pkg::PIR_OVF]
				&& pie_r[timer_one_pkg::PIR_OVF];
		end
	end

	// crystal amplifier: inverted input while enabled, sleep does not stop it
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			OSC_OUTPUT_PIN <= 1'b0;
			OSC_OUTPUT_OE <= 1'b0;
		end
		else
		begin
			OSC_OUTPUT_PIN <= !OSC_INPUT_PIN;
			OSC_OUTPUT_OE <= osc_en;
		end
	end

endmodule

// file: core/timer_one_pkg.sv
package timer_one_pkg;

	// register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0b;
	localparam logic [7:0] IDX_PERIPHERAL_IRQ_FLAGS = 8'h0c;
	localparam logic [7:0] IDX_COUNT_LOW_BYTE = 8'h0e;
	localparam logic [7:0] IDX_COUNT_HIGH_BYTE = 8'h0f;
	localparam logic [7:0] IDX_TIMER_CONTROL = 8'h10;
	localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLES = 8'h8c;
	// extra register: compare value pair, low byte and high byte
	localparam logic [7:0] IDX_COMPARE_LOW = 8'h15;
	localparam logic [7:0] IDX_COMPARE_HIGH = 8'h16;
	// extra register: compare mode field in bits 3:0
	localparam logic [7:0] IDX_COMPARE_MODE = 8'h17;

	// timer control field positions
	localparam int CTL_ON = 0;
	localparam int CTL_CLKSEL = 1;
	localparam int CTL_SYNC_DIS = 2;
	localparam int CTL_OSC_EN = 3;
	localparam int CTL_PS_LO = 4;
	localparam int CTL_PS_HI = 5;
	localparam logic [7:0] CTL_MASK = 8'h3f;
	localparam logic [7:0] CTL_RESET = 8'h00;

	// interrupt control field positions
	localparam int INTC_GIE = 7;
	localparam int INTC_PEIE = 6;
	localparam logic [7:0] INTC_RESET = 8'h00;

	// peripheral flag and enable positions
	localparam int PIR_OVF = 0;
	localparam logic [7:0] PIR_MASK = 8'hf7;
	localparam logic [7:0] PIR_RESET = 8'h00;
	localparam logic [7:0] PIE_RESET = 8'h00;

	localparam logic [3:0] MODE_SPECIAL_TRIGGER = 4'hb;

	// instruction clock is the oscillator divided by four
	localparam int PHASES_PER_CYCLE = 4;
	// increment follows the synchronised edge by this many phase ticks
	localparam int SYNC_INC_DELAY = 2;
	localparam logic [1:0] PHASE_SECOND = 2'h1;
	localparam logic [1:0] PHASE_FOURTH = 2'h3;
	localparam real CRYSTAL_KHZ = 32.768;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef struct packed {
		logic [7:0] idx;
		logic write;
	} bus_req_t;

	typedef enum {ST_IDLE, ST_WAIT} sync_state_t;

endpackage

// file: tb/ext_clock_src.sv
`timescale 1ns/100ps
// stand-in for the external count clock or the watch crystal
module ext_clock_src
(
	output logic ext_clk,
	output logic osc_in
);
	// both stand still low between bursts
	initial
	begin
		ext_clk = 1'b0;
		osc_in = 1'b0;
	end
	// only the chosen pin toggles; 400 ns levels clear the sampling window
	task automatic burst(input logic use_osc, input int n);
		#50;
		repeat (n)
		begin
			{osc_in, ext_clk} = use_osc ? 2'b10 : 2'b01;
			#400;
			{osc_in, ext_clk} = 2'b00;
			#400;
		end
	endtask
endmodule

// file: tb/sixteen_bit_timer_counter_bench.sv
`timescale 1ns/100ps
module sixteen_bit_timer_counter_bench;
	localparam logic [7:0] ctl_i = timer_one_pkg::IDX_TIMER_CONTROL;
	localparam logic [7:0] low_i = timer_one_pkg::IDX_COUNT_LOW_BYTE;
	localparam logic [7:0] high_i = timer_one_pkg::IDX_COUNT_HIGH_BYTE;
	localparam logic [7:0] flg_i = timer_one_pkg::IDX_PERIPHERAL_IRQ_FLAGS;
	typedef struct packed {logic [7:0] ctl; logic osc; logic [7:0] exp;} row_t;
	logic clk, rst, por, sleep, hsel, hwrite, ready, resp, osc_out, osc_oe, irq, wake;
	logic ext_clk, osc_in;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [7:0] v;
	int n_errors, compares, ticks;
	// control, pin, expected count after 16 edges; async rows cover dividers 1, 2 and 8 too
	row_t rows [8] = '{'{8'h03, 1'b0, 8'h10}, '{8'h13, 1'b0, 8'h08}, '{8'h23, 1'b0, 8'h04},
		'{8'h33, 1'b0, 8'h02}, '{8'h0b, 1'b1, 8'h10}, '{8'h07, 1'b0, 8'h10},
		'{8'h17, 1'b0, 8'h08}, '{8'h37, 1'b0, 8'h02}};
	timer_one i_dut (.CLOCK(clk), .RST(rst), .POR_RST(por), .SLEEP(sleep),
		.EXT_CLOCK_PIN(ext_clk), .OSC_INPUT_PIN(osc_in), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(timer_one_pkg::HSIZE_WORD), .HWDATA(hwdata),
		.HREADY(ready), .HRDATA(hrdata), .HREADYOUT(ready), .HRESP(resp),
		.OSC_OUTPUT_PIN(osc_out), .OSC_OUTPUT_OE(osc_oe), .IRQ(irq), .WAKE(wake));
	ext_clock_src i_src (.ext_clk(ext_clk), .osc_in(osc_in));
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic print_verdict;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// hang guard, far above the roughly 1700 cycles the run needs
	always @(posedge clk)
	begin
		ticks++;
		if (ticks == 20000)
		begin
			n_errors++;
			print_verdict;
		end
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one single transfer; entered just after a rising edge
	task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= wr;
		htrans <= timer_one_pkg::HTRANS_NONSEQ;
		do @(posedge clk); while (ready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge clk); while (ready !== 1'b1);
		v = hrdata[7:0];
	endtask
	task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
		bus(idx, 1'b0, 8'h00);
		chk(what, exp, v);
	endtask
	task automatic pulse_reset(input logic power);
		rst <= 1'b1;
		por <= power;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		@(posedge clk);
	endtask
	initial
	begin
		{sleep, hsel, hwrite, htrans, haddr, hwdata} = '0;
		rst = 1'b1;
		por = 1'b1;
		repeat (16) @(posedge clk);
		pulse_reset(1'b1);
		rdchk("control", ctl_i, 8'h00);
		rdchk("flags", flg_i, 8'h00);
		rdchk("enables", timer_one_pkg::IDX_PERIPHERAL_IRQ_ENABLES, 8'h00);
		bus(ctl_i, 1'b1, 8'hff);
		rdchk("control", ctl_i, 8'h3f);
		bus(8'h20, 1'b1, 8'hff);
		rdchk("unmapped", 8'h20, 8'h00);
		// stop, clear, then count 16 external edges per row
		foreach (rows[i])
		begin
			bus(ctl_i, 1'b1, 8'h00);
			bus(low_i, 1'b1, 8'h00);
			bus(high_i, 1'b1, 8'h00);
			bus(ctl_i, 1'b1, rows[i].ctl);
			repeat (4) @(posedge clk);
			i_src.burst(rows[i].osc, 16);
			repeat (8) @(posedge clk);
			rdchk("count", low_i, rows[i].exp);
		end
		// prescaler cleared by a count write in mid division
		bus(ctl_i, 1'b1, 8'h33);
		bus(low_i, 1'b1, 8'h00);
		i_src.burst(1'b0, 3);
		@(posedge clk);
		bus(low_i, 1'b1, 8'h00);
		i_src.burst(1'b0, 3);
		repeat (8) @(posedge clk);
		rdchk("count", low_i, 8'h00);
		// sleeping: synchronised count holds, asynchronous keeps going
		sleep <= 1'b1;
		bus(ctl_i, 1'b1, 8'h03);
		bus(low_i, 1'b1, 8'h00);
		i_src.burst(1'b0, 8);
		repeat (8) @(posedge clk);
		rdchk("count", low_i, 8'h00);
		bus(ctl_i, 1'b1, 8'h07);
		i_src.burst(1'b0, 8);
		repeat (8) @(posedge clk);
		rdchk("count", low_i, 8'h08);
		sleep <= 1'b0;
		// timer mode rolls over, raises the flag and interrupt
		bus(ctl_i, 1'b1, 8'h00);
		bus(low_i, 1'b1, 8'hfe);
		bus(high_i, 1'b1, 8'hff);
		bus(timer_one_pkg::IDX_PERIPHERAL_IRQ_ENABLES, 1'b1, 8'h01);
		bus(timer_one_pkg::IDX_INTERRUPT_CONTROL, 1'b1, 8'hc0);
		bus(ctl_i, 1'b1, 8'h05);
		repeat (40) @(posedge clk);
		bus(ctl_i, 1'b1, 8'h00);
		// 42 enabled edges at one tick per four give ten or eleven ticks
		bus(low_i, 1'b0, 8'h00);
		chk("low", 8'h01, {7'h0, v inside {[8'h08:8'h09]}});
		rdchk("high", high_i, 8'h00);
		chk("irq", 8'h01, {7'h0, irq});
		rdchk("flags", flg_i, 8'h01);
		sleep <= 1'b1;
		repeat (3) @(posedge clk);
		chk("wake", 8'h01, {7'h0, wake});
		sleep <= 1'b0;
		bus(flg_i, 1'b1, 8'h00);
		repeat (3) @(posedge clk);
		chk("irq", 8'h00, {7'h0, irq});
		// compare trigger wraps the count at the compare value
		bus(timer_one_pkg::IDX_COMPARE_LOW, 1'b1, 8'h05);
		bus(timer_one_pkg::IDX_COMPARE_HIGH, 1'b1, 8'h00);
		bus(timer_one_pkg::IDX_COMPARE_MODE, 1'b1, timer_one_pkg::MODE_SPECIAL_TRIGGER);
		bus(low_i, 1'b1, 8'h00);
		bus(high_i, 1'b1, 8'h00);
		bus(ctl_i, 1'b1, 8'h01);
		repeat (100) @(posedge clk);
		bus(ctl_i, 1'b1, 8'h00);
		rdchk("high", high_i, 8'h00);
		bus(low_i, 1'b0, 8'h00);
		chk("wrap", 8'h01, {7'h0, v <= 8'h05});
		rdchk("flags", flg_i, 8'h00);
		// compare at all ones: the trigger, not a rollover, must bring the count to zero
		bus(timer_one_pkg::IDX_COMPARE_LOW, 1'b1, 8'hff);
		bus(timer_one_pkg::IDX_COMPARE_HIGH, 1'b1, 8'hff);
		bus(low_i, 1'b1, 8'hfe);
		bus(high_i, 1'b1, 8'hff);
		bus(ctl_i, 1'b1, 8'h01);
		repeat (20) @(posedge clk);
		bus(ctl_i, 1'b1, 8'h00);
		rdchk("high", high_i, 8'h00);
		rdchk("flags", flg_i, 8'h00);
		// resets keep the count; only power-on clears control
		bus(ctl_i, 1'b1, 8'h30);
		bus(low_i, 1'b1, 8'h34);
		bus(high_i, 1'b1, 8'h12);
		rdchk("high", high_i, 8'h12);
		rdchk("low", low_i, 8'h34);
		rdchk("high", high_i, 8'h12);
		pulse_reset(1'b0);
		rdchk("control", ctl_i, 8'h30);
		rdchk("high", high_i, 8'h12);
		pulse_reset(1'b1);
		rdchk("control", ctl_i, 8'h00);
		rdchk("low", low_i, 8'h34);
		print_verdict;
	end
endmodule

// file: tb/timer_one_props.sv
`timescale 1ns/100ps
module timer_one_props
(
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic SLEEP,
	input wire logic OSC_INPUT_PIN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic OSC_OUTPUT_PIN,
	input wire logic OSC_OUTPUT_OE,
	input wire logic WAKE
);
	logic rd_r, gap_r, wr_ctl_r, oe_exp_r;
	logic [1:0] live_r;
	wire logic take = HSEL && HREADY && HTRANS == timer_one_pkg::HTRANS_NONSEQ;
	// data phase trackers; live_r skips edges where reset values linger
	always_ff @(posedge CLOCK or posedge RST)
	if (RST)
	begin
		rd_r <= 1'b0;
		gap_r <= 1'b0;
		wr_ctl_r <= 1'b0;
		oe_exp_r <= 1'b0;
		live_r <= 2'h0;
	end
	else
	begin
		rd_r <= take && !HWRITE;
		gap_r <= take && !HWRITE && HADDR[11:0] == 12'h080;
		wr_ctl_r <= take && HWRITE && HADDR[11:0] == 12'h040;
		live_r <= {live_r[0], 1'b1};
		if (wr_ctl_r)
			oe_exp_r <= HWDATA[3];
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	// enable may pass through one extra register before the pin
	sequence oe_settle_s;
		##[2:3] OSC_OUTPUT_OE == oe_exp_r;
	endsequence
	resp_okay_a: assert property (HRESP == 1'b0) else $error("error response seen");
	no_wait_a: assert property (live_r[0] |-> HREADYOUT) else $error("wait state seen");
	data_width_a: assert property (rd_r |-> HRDATA[31:8] == 24'h0)
		else $error("read data above byte lane");
	data_hold_a: assert property (!rd_r && live_r[1] |-> $stable(HRDATA))
		else $error("read data moved without a read");
	unmapped_zero_a: assert property (gap_r |-> HRDATA == 32'h0)
		else $error("unmapped read not zero");
	wake_cause_a: assert property ($rose(WAKE) |-> $past(SLEEP))
		else $error("wake without sleep");
	osc_invert_a: assert property (live_r[1] |-> OSC_OUTPUT_PIN == !$past(OSC_INPUT_PIN))
		else $error("oscillator output not inverted");
	osc_enable_a: assert property (wr_ctl_r |-> oe_settle_s)
		else $error("oscillator enable not followed");
endmodule
bind timer_one timer_one_props i_props (.CLOCK, .RST, .SLEEP, .OSC_INPUT_PIN, .HSEL, .HADDR,
	.HTRANS, .HWRITE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .OSC_OUTPUT_PIN,
	.OSC_OUTPUT_OE, .WAKE);
